// File: cdio_pkg.sv
/*
  cdio_pkg: register map, field codes, reset values and timing counts for the
  digital line unit. Assumes a 32-bit APB slave, one aligned word per register.
*/
package cdio_pkg;
  localparam int unsigned NUM_LINES     = 4;
  localparam int unsigned NUM_SOFT_OUTS = 4;
  localparam int unsigned CLK_MHZ       = 25;
  localparam int unsigned US_CYCLES     = CLK_MHZ;
  localparam int unsigned SPAN_W        = 16;

  // register byte offsets
  localparam logic [7:0] OFF_LINE_PICK     = 8'h00;
  localparam logic [7:0] OFF_LINE_CFG      = 8'h04;
  localparam logic [7:0] OFF_FILTER_KIND   = 8'h08;
  localparam logic [7:0] OFF_FILTER_SPAN   = 8'h0C;
  localparam logic [7:0] OFF_LINE_STATUS   = 8'h10;
  localparam logic [7:0] OFF_ALL_LEVELS    = 8'h14;
  localparam logic [7:0] OFF_SOFT_PICK     = 8'h18;
  localparam logic [7:0] OFF_SOFT_LEVEL    = 8'h1C;
  localparam logic [7:0] OFF_ALL_SOFT      = 8'h20;

  // fields of the line configuration word
  localparam int unsigned CFG_DIR_BIT      = 0;
  localparam int unsigned CFG_FLIP_BIT     = 1;
  localparam int unsigned CFG_RAIL_BIT     = 2;
  localparam int unsigned CFG_SRC_LSB      = 8;
  localparam int unsigned SRC_W            = 5;
  // fields of the line status word
  localparam int unsigned STAT_LEVEL_BIT   = 0;
  localparam int unsigned STAT_FMT_LSB     = 4;
  localparam int unsigned FMT_W            = 3;

  // drive source codes
  localparam logic [4:0] SRC_OFF           = 5'h00;
  localparam logic [4:0] SRC_LINE0         = 5'h01;
  localparam logic [4:0] SRC_SOFT0         = 5'h05;
  localparam logic [4:0] SRC_EXT0          = 5'h09;
  localparam int unsigned NUM_EXT_SRC      = 9;

  // electrical circuit type codes
  localparam logic [2:0] FMT_NOCONNECT     = 3'h0;
  localparam logic [2:0] FMT_TRISTATE      = 3'h1;
  localparam logic [2:0] FMT_OPTO          = 3'h5;
  localparam logic [2:0] FMT_OPENDRAIN     = 3'h6;

  localparam logic [SPAN_W-1:0] SPAN_RESET = 16'h0000;
  localparam logic [31:0] RDATA_ZERO       = 32'h00000000;
endpackage

// File: cdio_lines.sv
/*
  cdio_lines: four connector lines with direction, polarity flip, aux rail
  enable, deglitch and debounce filters, drive source select and soft outputs,
  all behind an APB slave. Assumes line pins are asynchronous to pclk and that
  the acquisition signals on ext_src arrive already synchronous to pclk.
*/
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module cdio_lines #(
  parameter int unsigned LINES = cdio_pkg::NUM_LINES,
  parameter logic [LINES-1:0] RAIL_MASK = 4'b0100,
  parameter logic [LINES*cdio_pkg::FMT_W-1:0] LINE_FMT =
    {cdio_pkg::FMT_TRISTATE, cdio_pkg::FMT_OPENDRAIN, cdio_pkg::FMT_OPTO, cdio_pkg::FMT_OPTO}
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic [LINES-1:0]               line_in,
  output logic      [LINES-1:0]               line_out,
  output logic      [LINES-1:0]               line_oe_n,
  output logic      [LINES-1:0]               aux_rail_on,
  input  wire logic [cdio_pkg::NUM_EXT_SRC-1:0] ext_src
);
  localparam int unsigned SW = cdio_pkg::SPAN_W;

  // the two-bit pickers, the 4-bit reset words and the loop-back codes 1..4 all assume four lines
  if (LINES != 4) begin : g_bad_lines
    $error("cdio_lines serves exactly four lines");
  end

  // register map, one aligned word each; reserved bits read as zero:
  //   00  line pick, bits 1:0
  //   04  line config of the picked line:
  //         bit 0     direction, set for output
  //         bit 1     polarity flip, acts on input and output alike
  //         bit 2     aux rail enable, kept only where RAIL_MASK allows
  //         bits 12:8 drive source code
  //   08  filter kind of the picked line, bit 0: clear deglitch, set debounce
  //   0C  filter width in microseconds for picked line and kind, bits 15:0
  //   10  status of the picked line: bit 0 level, bits 6:4 circuit type
  //   14  levels of all lines, bit n for line n
  //   18  soft output pick, bits 1:0
  //   1C  level of the picked soft output, bit 0
  //   20  all soft outputs, bit n for soft output n, read and write
  // any other offset answers with pslverr, writes nothing and reads zero
  //
  // drive source codes:
  //   0       off, driver stays released
  //   1..4    loop back of line 0..3 level
  //   5..8    soft output 0..3
  //   9..17   ext_src bit 0..8
  //   18..31  not assigned; they drive low before the flip so no unknown reaches a pin
  //
  // bus timing: one wait state. the first access cycle is decoded and its
  // answer registered, so pready, prdata and pslverr stand for exactly one
  // cycle. a write lands on the edge at which pready rises; the master still
  // holds its request until it samples pready high one edge later, and the
  // !pready term keeps that second access cycle from being decoded again.

  // register state
  logic [1:0]            line_pick_q, line_pick_d;
  logic [1:0]            soft_output_pick_q, soft_output_pick_d;
  logic [LINES-1:0]      line_direction_q, line_direction_d;
  logic [LINES-1:0]      line_polarity_flip_q, line_polarity_flip_d;
  logic [LINES-1:0]      rail_q, rail_d;
  logic [LINES-1:0]      input_filter_kind_q, input_filter_kind_d;
  logic [cdio_pkg::SRC_W-1:0] drive_sel_q [LINES];
  logic [cdio_pkg::SRC_W-1:0] drive_sel_d [LINES];
  logic [SW-1:0]         span_q [LINES][2];
  logic [SW-1:0]         span_d [LINES][2];
  logic [cdio_pkg::NUM_SOFT_OUTS-1:0] soft_q, soft_d;
  logic [31:0]           prdata_d;
  logic                  pready_d, pslverr_d;

  // input path state
  logic [LINES-1:0]      s1_q, s2_q, s3_q;
  logic [LINES-1:0]      dg_q, dg_d;
  logic [LINES-1:0]      db_q, db_d;
  logic [LINES-1:0]      level_q, level_d;
  logic [LINES-1:0]      out_q, out_d, oe_n_d;
  logic [SW+5:0]         dg_cnt_q [LINES];
  logic [SW+5:0]         dg_cnt_d [LINES];
  logic [SW+5:0]         db_cnt_q [LINES];
  logic [SW+5:0]         db_cnt_d [LINES];
  logic [LINES-1:0]      raw_in;

  // width in microseconds to clock cycles
  function automatic logic [SW+5:0] span_cycles(input logic [SW-1:0] us);
    span_cycles = (SW+6)'(us * cdio_pkg::US_CYCLES);
  endfunction

  function automatic logic [1:0] field_pick(input logic [31:0] w);
    field_pick = w[1:0];
  endfunction

  logic access;
  assign access = psel && penable;
  logic [1:0] lp;
  assign lp = line_pick_q;

  // APB decode: one-wait-state answer, registered; unmapped offsets give pslverr
  always_comb begin
    line_pick_d          = line_pick_q;
    soft_output_pick_d   = soft_output_pick_q;
    line_direction_d     = line_direction_q;
    line_polarity_flip_d = line_polarity_flip_q;
    rail_d               = rail_q;
    input_filter_kind_d  = input_filter_kind_q;
    drive_sel_d          = drive_sel_q;
    span_d               = span_q;
    soft_d               = soft_q;
    prdata_d             = cdio_pkg::RDATA_ZERO;
    pready_d             = access && !pready;
    pslverr_d            = 1'b0;
    if (access && !pready) begin
      unique case (paddr)
        cdio_pkg::OFF_LINE_PICK: begin
          if (pwrite) line_pick_d = field_pick(pwdata);
          prdata_d[1:0] = line_pick_q;
        end
        cdio_pkg::OFF_LINE_CFG: begin
          if (pwrite) begin
            line_direction_d[lp]     = pwdata[cdio_pkg::CFG_DIR_BIT];
            line_polarity_flip_d[lp] = pwdata[cdio_pkg::CFG_FLIP_BIT];
            rail_d[lp]               = pwdata[cdio_pkg::CFG_RAIL_BIT] & RAIL_MASK[lp];
            drive_sel_d[lp]          = pwdata[cdio_pkg::CFG_SRC_LSB +: cdio_pkg::SRC_W];
          end
          prdata_d[cdio_pkg::CFG_DIR_BIT]  = line_direction_q[lp];
          prdata_d[cdio_pkg::CFG_FLIP_BIT] = line_polarity_flip_q[lp];
          prdata_d[cdio_pkg::CFG_RAIL_BIT] = rail_q[lp];
          prdata_d[cdio_pkg::CFG_SRC_LSB +: cdio_pkg::SRC_W] = drive_sel_q[lp];
        end
        cdio_pkg::OFF_FILTER_KIND: begin
          if (pwrite) input_filter_kind_d[lp] = pwdata[0];
          prdata_d[0] = input_filter_kind_q[lp];
        end
        cdio_pkg::OFF_FILTER_SPAN: begin
          if (pwrite) span_d[lp][input_filter_kind_q[lp]] = pwdata[SW-1:0];
          prdata_d[SW-1:0] = span_q[lp][input_filter_kind_q[lp]];
        end
        cdio_pkg::OFF_LINE_STATUS: begin
          prdata_d[cdio_pkg::STAT_LEVEL_BIT] = level_q[lp];
          prdata_d[cdio_pkg::STAT_FMT_LSB +: cdio_pkg::FMT_W] =
            LINE_FMT[lp*cdio_pkg::FMT_W +: cdio_pkg::FMT_W];
        end
        cdio_pkg::OFF_ALL_LEVELS: begin
          prdata_d[LINES-1:0] = level_q;
        end
        cdio_pkg::OFF_SOFT_PICK: begin
          if (pwrite) soft_output_pick_d = field_pick(pwdata);
          prdata_d[1:0] = soft_output_pick_q;
        end
        cdio_pkg::OFF_SOFT_LEVEL: begin
          if (pwrite) soft_d[soft_output_pick_q] = pwdata[0];
          prdata_d[0] = soft_q[soft_output_pick_q];
        end
        cdio_pkg::OFF_ALL_SOFT: begin
          if (pwrite) soft_d = pwdata[cdio_pkg::NUM_SOFT_OUTS-1:0];
          prdata_d[cdio_pkg::NUM_SOFT_OUTS-1:0] = soft_q;
        end
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_pick_q          <= 2'h0;
      soft_output_pick_q   <= 2'h0;
      line_direction_q     <= 4'h0;
      line_polarity_flip_q <= 4'h0;
      rail_q               <= 4'h0;
      input_filter_kind_q  <= 4'h0;
      soft_q               <= 4'h0;
      prdata               <= cdio_pkg::RDATA_ZERO;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
      for (int i = 0; i < LINES; i++) begin
        drive_sel_q[i] <= cdio_pkg::SRC_OFF;
        span_q[i][0]   <= cdio_pkg::SPAN_RESET;
        span_q[i][1]   <= cdio_pkg::SPAN_RESET;
      end
    end else begin
      line_pick_q          <= line_pick_d;
      soft_output_pick_q   <= soft_output_pick_d;
      line_direction_q     <= line_direction_d;
      line_polarity_flip_q <= line_polarity_flip_d;
      rail_q               <= rail_d;
      input_filter_kind_q  <= input_filter_kind_d;
      soft_q               <= soft_d;
      prdata               <= prdata_d;
      pready               <= pready_d;
      pslverr              <= pslverr_d;
      drive_sel_q          <= drive_sel_d;
      span_q               <= span_d;
    end
  end

  // pin synchroniser: a change counts only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end else begin
      s1_q <= line_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // filters: deglitch then debounce; a zero width passes the signal through.
  // deglitch counts cycles in which the synchronised input differs from its
  // accepted state and only takes the new state once the count reaches the
  // width; any return to the old state clears the count, so short pulses die.
  // debounce copies a change at once and then holds a lockout count, so
  // contact bounce inside the lockout is ignored. widths are read live: a
  // deglitch width written mid-count applies at once; a debounce width only takes effect for the next change.
  // counters are six bits wider than the width so 25 cycles per microsecond
  // never wrap for the largest width.
  always_comb begin
    dg_d     = dg_q;
    db_d     = db_q;
    dg_cnt_d = dg_cnt_q;
    db_cnt_d = db_cnt_q;
    raw_in   = dg_q;
    for (int i = 0; i < LINES; i++) begin
      if (s2_q[i] == s3_q[i]) raw_in[i] = s3_q[i];
      // deglitch waits the full width of stable new state
      if (raw_in[i] == dg_q[i]) begin
        dg_cnt_d[i] = '0;
      end else if (dg_cnt_q[i] + 1'b1 >= span_cycles(span_q[i][0])) begin
        dg_d[i]     = raw_in[i];
        dg_cnt_d[i] = '0;
      end else begin
        dg_cnt_d[i] = dg_cnt_q[i] + 1'b1;
      end
      // debounce takes the edge now, then locks out; fed from deglitch
      if (db_cnt_q[i] != '0) begin
        db_cnt_d[i] = db_cnt_q[i] - 1'b1;
      end else if (dg_d[i] != db_q[i]) begin
        db_d[i]     = dg_d[i];
        db_cnt_d[i] = span_cycles(span_q[i][1]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dg_q <= 4'h0;
      db_q <= 4'h0;
      for (int i = 0; i < LINES; i++) begin
        dg_cnt_q[i] <= '0;
        db_cnt_q[i] <= '0;
      end
    end else begin
      dg_q     <= dg_d;
      db_q     <= db_d;
      dg_cnt_q <= dg_cnt_d;
      db_cnt_q <= db_cnt_d;
    end
  end

  // drive and level: pin low-active enable, push-pull level out.
  // an output line reports its source level before the flip, an input line
  // reports the filtered pin level after the flip. a loop back from a line
  // reads the registered level, so a line looped onto itself settles one
  // cycle later instead of forming a combinational ring.
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      logic src;
      src = 1'b0;
      if (drive_sel_q[i] >= cdio_pkg::SRC_EXT0 + cdio_pkg::NUM_EXT_SRC)
        src = 1'b0; // unassigned codes drive low before the flip
      else if (drive_sel_q[i] >= cdio_pkg::SRC_EXT0)
        src = ext_src[4'(drive_sel_q[i] - cdio_pkg::SRC_EXT0)];
      else if (drive_sel_q[i] >= cdio_pkg::SRC_SOFT0)
        src = soft_q[2'(drive_sel_q[i] - cdio_pkg::SRC_SOFT0)];
      else if (drive_sel_q[i] >= cdio_pkg::SRC_LINE0)
        src = level_q[2'(drive_sel_q[i] - cdio_pkg::SRC_LINE0)]; // loop back
      out_d[i]   = src ^ line_polarity_flip_q[i];
      // input lines keep the driver off whatever the source says
      oe_n_d[i]  = !(line_direction_q[i] && drive_sel_q[i] != cdio_pkg::SRC_OFF);
      level_d[i] = line_direction_q[i] ? src : (db_q[i] ^ line_polarity_flip_q[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q       <= 4'h0;
      line_oe_n   <= 4'hF;
      level_q     <= 4'h0;
      aux_rail_on <= 4'h0;
    end else begin
      out_q       <= out_d;
      line_oe_n   <= oe_n_d;
      level_q     <= level_d;
      aux_rail_on <= rail_q;
    end
  end
  assign line_out = out_q;
endmodule

// File: cdio_lines_asserts.sv
/* cdio_lines_asserts: port checks for cdio_lines.
   assumes one pclk domain and async active-low presetn. */
`timescale 1ns/1ps
module cdio_lines_asserts #(
  parameter logic [3:0] RAIL_MASK = 4'b0100
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  line_oe_n,
  input wire logic [3:0]  aux_rail_on
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // one wait state, then a single-cycle answer
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after wait state");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data nonzero");
  a_status_reserved: assert property (pready && !pwrite && !pslverr && paddr == cdio_pkg::OFF_LINE_STATUS
    |-> prdata[31:7] == 25'h0 && prdata[3:1] == 3'h0) else $error("status reserved bits set");
  a_levels_width: assert property (pready && !pwrite && !pslverr && paddr == cdio_pkg::OFF_ALL_LEVELS
    |-> prdata[31:4] == 28'h0) else $error("level word too wide");
  a_rail_masked: assert property ((aux_rail_on & ~RAIL_MASK) == 4'h0) else $error("rail on bad line");
  // drivers and rails may only move as a result of a register write
  a_drive_by_write: assert property ($changed(line_oe_n) |-> $past(psel && pwrite) ||
    $past(psel && pwrite, 2)) else $error("driver enable moved without write");
  a_rail_by_write: assert property ($changed(aux_rail_on) |-> $past(psel && pwrite) ||
    $past(psel && pwrite, 2)) else $error("rail moved without write");
endmodule

bind cdio_lines cdio_lines_asserts #(.RAIL_MASK(RAIL_MASK)) cdio_lines_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_oe_n(line_oe_n), .aux_rail_on(aux_rail_on));

// File: cdio_ext_model.sv
/* cdio_ext_model: external circuits on the four connector lines.
   assumes pulled-up wires; a line the device drives reads back its drive. */
`timescale 1ns/1ps
module cdio_ext_model (
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe_n,
  input wire logic [3:0] ext_drive,
  input wire logic [3:0] ext_en,
  output logic     [3:0] line_in
);
  // undriven lines float to the pull-up so stale values never linger
  assign line_in = (~line_oe_n & line_out) | (line_oe_n & ((ext_en & ext_drive) | ~ext_en));
endmodule

// File: cdio_lines_tb_top.sv
/* cdio_lines_tb_top: scenario tests for cdio_lines over APB.
   assumes the default four lines with the rail on line 2 only. */
`timescale 1ns/1ps
module cdio_lines_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  line_in, line_out, line_oe_n, aux_rail_on, ext_drive, ext_en;
  logic [8:0]  ext_src;
  logic [2:0]  fmt [4] = '{cdio_pkg::FMT_OPTO, cdio_pkg::FMT_OPTO, cdio_pkg::FMT_OPENDRAIN, cdio_pkg::FMT_TRISTATE};
  int          errors, num_checks;

  cdio_lines cdio_lines_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .line_out(line_out), .line_oe_n(line_oe_n), .aux_rail_on(aux_rail_on), .ext_src(ext_src));
  cdio_ext_model cdio_ext_model_i (.line_out(line_out), .line_oe_n(line_oe_n), .ext_drive(ext_drive),
    .ext_en(ext_en), .line_in(line_in));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task final_report;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // one APB transfer; idles a cycle after so strobes never toggle twice in a step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("[FAIL] t=%0t apb timeout got=%h exp=%h", $time, pready, 1'b1);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  task t_reset;
    chk({28'h0, line_oe_n}, 32'hF);
    rd(cdio_pkg::OFF_LINE_PICK, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(cdio_pkg::OFF_LINE_PICK, i);
      rd(cdio_pkg::OFF_LINE_STATUS, {25'h0, fmt[i], 4'h0});
    end
    $display("t_reset done");
  endtask

  task t_soft;
    wr(cdio_pkg::OFF_SOFT_PICK, 32'h1);
    wr(cdio_pkg::OFF_SOFT_LEVEL, 32'h1);
    wr(cdio_pkg::OFF_SOFT_PICK, 32'h3);
    wr(cdio_pkg::OFF_SOFT_LEVEL, 32'h1);
    rd(cdio_pkg::OFF_SOFT_LEVEL, 32'h1);
    rd(cdio_pkg::OFF_ALL_SOFT, 32'hA);
    wr(cdio_pkg::OFF_LINE_PICK, 32'h1);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h601);
    repeat (4) @(posedge pclk);
    chk({30'h0, line_oe_n[1], line_out[1]}, 32'h1);
    rd(cdio_pkg::OFF_ALL_LEVELS, 32'h2);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h603);
    repeat (4) @(posedge pclk);
    chk({31'h0, line_out[1]}, 32'h0);
    rd(cdio_pkg::OFF_LINE_STATUS, 32'h51);
    ext_src <= 9'h010;
    wr(cdio_pkg::OFF_LINE_CFG, 32'hD01);
    repeat (4) @(posedge pclk);
    chk({31'h0, line_out[1]}, 32'h1);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h1);
    repeat (4) @(posedge pclk);
    chk({31'h0, line_oe_n[1]}, 32'h1);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h600);
    repeat (4) @(posedge pclk);
    chk({31'h0, line_oe_n[1]}, 32'h1);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h0);
    $display("t_soft done");
  endtask

  task t_rail;
    wr(cdio_pkg::OFF_LINE_PICK, 32'h2);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h4);
    repeat (2) @(posedge pclk);
    chk({28'h0, aux_rail_on}, 32'h4);
    rd(cdio_pkg::OFF_LINE_CFG, 32'h4);
    wr(cdio_pkg::OFF_LINE_PICK, 32'h0);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h4);
    repeat (2) @(posedge pclk);
    chk({28'h0, aux_rail_on}, 32'h4);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h0);
    $display("t_rail done");
  endtask

  task t_input;
    wr(cdio_pkg::OFF_LINE_PICK, 32'h3);
    ext_drive <= 4'h8;
    repeat (8) @(posedge pclk);
    rd(cdio_pkg::OFF_ALL_LEVELS, 32'h8);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h2);
    repeat (8) @(posedge pclk);
    rd(cdio_pkg::OFF_LINE_STATUS, 32'h10);
    wr(cdio_pkg::OFF_LINE_CFG, 32'h0);
    ext_drive <= 4'h0;
    $display("t_input done");
  endtask

  // span 1 us = 25 cycles deglitch, then 2 us = 50 cycles debounce
  task t_filter;
    wr(cdio_pkg::OFF_LINE_PICK, 32'h0);
    wr(cdio_pkg::OFF_FILTER_KIND, 32'h0);
    wr(cdio_pkg::OFF_FILTER_SPAN, 32'h1);
    ext_drive <= 4'h1;
    repeat (10) @(posedge pclk);
    ext_drive <= 4'h0;
    repeat (40) @(posedge pclk);
    rd(cdio_pkg::OFF_ALL_LEVELS, 32'h0);
    ext_drive <= 4'h1;
    repeat (60) @(posedge pclk);
    rd(cdio_pkg::OFF_ALL_LEVELS, 32'h1);
    wr(cdio_pkg::OFF_FILTER_SPAN, 32'h0);
    wr(cdio_pkg::OFF_FILTER_KIND, 32'h1);
    wr(cdio_pkg::OFF_FILTER_SPAN, 32'h2);
    rd(cdio_pkg::OFF_FILTER_SPAN, 32'h2);
    wr(cdio_pkg::OFF_FILTER_KIND, 32'h0);
    rd(cdio_pkg::OFF_FILTER_SPAN, 32'h0);
    ext_drive <= 4'h0;
    repeat (8) @(posedge pclk);
    rd(cdio_pkg::OFF_ALL_LEVELS, 32'h0);
    ext_drive <= 4'h1;
    repeat (4) @(posedge pclk);
    rd(cdio_pkg::OFF_ALL_LEVELS, 32'h0);
    repeat (60) @(posedge pclk);
    rd(cdio_pkg::OFF_ALL_LEVELS, 32'h1);
    $display("t_filter done");
  endtask

  task t_map;
    apb(1'b0, 8'h40, 32'h0);
    chk({e, r[30:0]}, 32'h80000000);
    apb(1'b1, 8'h44, 32'h5);
    chk({31'h0, e}, 32'h1);
    $display("t_map done");
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ext_src, ext_drive} = '0;
    ext_en = 4'hF;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_soft;
    t_rail;
    t_input;
    t_filter;
    t_map;
    final_report;
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    errors++;
    $display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
    final_report;
  end
endmodule
